// [hw/rfs_map.svh]
// Register map, field positions, reset values and frame counts of the
// serial slave identity and status bank.
// Assumes inclusion by bare name from every file that decodes the map.
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH

// Register offsets.
`define RFS_ADR_MODE 8'h00
`define RFS_ADR_STATUS 8'h1A
`define RFS_ADR_GROUP 8'h1B
`define RFS_ADR_PWR 8'h1C
`define RFS_ADR_PART 8'h1D
`define RFS_ADR_MAKER_LO 8'h1E
`define RFS_ADR_MAKER_HI 8'h1F
`define RFS_ADR_PART_EXT 8'h20

// Field positions.
`define RFS_STAT_SWRST 7
`define RFS_PWR_STATE_FLD 7:6
`define RFS_PWR_MASK_FLD 5:3
`define RFS_PWR_TRIG_FLD 2:0
`define RFS_UNIQUE_SLAVE_ADDRESS_FLD 3:0
`define RFS_GROUP_FLD 3:0
`define RFS_MAKER_LO_FLD 7:0
`define RFS_MAKER_TOP_FLD 9:8
`define RFS_MODE_FLD 6:0

// Reset values and fixed codes.
`define RFS_UNIQUE_SLAVE_ADDRESS_RST 4'hB
`define RFS_GROUP_RST 4'h0
`define RFS_MODE_RST 7'h00
`define RFS_STATUS_RST 7'h00
`define RFS_PSTATE_RST 2'h0
`define RFS_MASK_RST 3'h0
`define RFS_PWR_RESERVED 2'h3
`define RFS_BCAST_ID 4'h0

// Frame layout: command frame is slave address, command, parity.
`define RFS_PIN_W 3
`define RFS_CMD_LAST 4'hC
`define RFS_BYTE_LAST 4'h8
`define RFS_BYTE_DONE 4'h9
`define RFS_FRM_SA 12:9
`define RFS_FRM_CMD 8:1
`define RFS_FRM_DATA 8:1
`define RFS_CMD_R0W 7
`define RFS_CMD_R0DATA 6:0
`define RFS_CMD_OP3 7:5
`define RFS_CMD_OP4 7:4
`define RFS_CMD_RADR 4:0
`define RFS_CMD_BC 3:0
`define RFS_OP_RW 3'h2
`define RFS_OP_RR 3'h3
`define RFS_OP_EW 4'h0
`define RFS_OP_ER 4'h2

`endif

// [hw/rfs_pkg.sv]
// Types shared by the serial slave identity and status bank.
// Assumes nothing of its surroundings.
`default_nettype none

package rfs_pkg;

	typedef enum logic [7:0] {
		st_idle = 8'h01,
		st_cmd = 8'h02,
		st_addr = 8'h04,
		st_wdata = 8'h08,
		st_turn = 8'h10,
		st_rdata = 8'h20,
		st_rpark = 8'h40,
		st_wpark = 8'h80
	} rfs_state_t;

	// Error events, in the bit order of the fault flag register.
	typedef struct packed {
		logic cmd_par;
		logic cmd_len;
		logic adr_par;
		logic dat_par;
		logic rd_unused;
		logic wr_unused;
		logic shared_id_read_fault;
	} rfs_err_t;

	// One register write taken from the link.
	typedef struct packed {
		logic en;
		logic shared;
		logic [7:0] addr;
		logic [7:0] data;
	} rfs_wr_t;

endpackage : rfs_pkg

`default_nettype wire

// [hw/rfs_pin_sync.sv]
// Two-flop synchroniser for the link pins, with a third flop that holds
// the synchronised level one clock earlier for edge detection.
// Assumes pins change with no relation to clk.
`include "rfs_map.svh"
`default_nettype none

module rfs_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Raw pins
	input wire logic [`RFS_PIN_W-1:0] pin_in,
	// Synchronised level and its previous value
	output logic [`RFS_PIN_W-1:0] pin_s,
	output logic [`RFS_PIN_W-1:0] pin_prev
);

	logic [`RFS_PIN_W-1:0] meta_ff;
	logic [`RFS_PIN_W-1:0] sync_ff;
	logic [`RFS_PIN_W-1:0] prev_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign pin_s = sync_ff;
	assign pin_prev = prev_ff;

endmodule : rfs_pin_sync

`default_nettype wire

// [hw/rfs_slave_regs.sv]
// Serial front-end slave: frame decoder, identity registers, fault flags,
// power trigger control and the switch mode register it stages.
// Assumes sclk, serial_data_line and the trigger scope strap are asynchronous pins
// and that clk runs far faster than sclk.
//
// Notes on behaviour
// [RQ1] The 10-bit maker code reads back as low byte at 0x1E and top bits in 5:4 of 0x1F, and writes never change it.
// [RQ2] The unique slave address sits in bits 3:0 of 0x1F, resets to 0xB and is reprogrammed by a write there.
// [RQ3] Writing one to status bit 7 restores every configurable register except slave address, group address and trigger control.
// [RQ4] A command frame with bad parity is dropped and sets bit 6; a frame cut short by a new start sets bit 5 (code: not for a cut command frame).
// [RQ5] A bad parity on an address frame sets bit 4.
// [RQ6] A bad parity on a data frame sets bit 3 and the write is dropped.
// [RQ7] A read of an address that is not implemented sets bit 2.
// [RQ8] A write to an address that is not implemented sets bit 1.
// [RQ9] A read sent to the broadcast or group address sets bit 0 and gets no answer.
// [RQ10] A read-only part code extension byte sits at 0x20.
// [RQ11] With the scope strap low any trigger loads the mode register; with it open only its own trigger does.
// [RQ12] Writing one to trigger bit 0, 1 or 2 loads the staged values of that trigger's registers.
// [RQ13] A set mask bit disables its trigger and writes to its registers then go straight through.
// [RQ14] The power state field encodes active, start-up, low power, and the reserved code is not taken.
// [RQ15] Fault flags stay set until a software reset, a power cycle or a write clears them.
// [RQ16] The master uses the unique address, or group address for writes only, and never reads by broadcast or group.
`include "rfs_map.svh"
`default_nettype none

module rfs_slave_regs #(
	// Identity codes; the values are arbitrary.
	parameter logic [9:0] MAKER_CODE = 10'h155,
	parameter logic [7:0] PART_CODE = 8'h5A,
	parameter logic [7:0] PART_CODE_EXT = 8'h3C
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Serial link
	input wire logic sclk,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe,
	// Trigger scope strap, high when the pin is left open
	input wire logic trig_scope_open,
	// Switch control
	output logic [6:0] mode_ctrl,
	output logic [1:0] power_state
);

	// ---------------------------------------------------------------
	// Pin synchronisation and edges
	// ---------------------------------------------------------------
	logic [`RFS_PIN_W-1:0] pin_s;
	logic [`RFS_PIN_W-1:0] pin_p;

	rfs_pin_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.pin_in({trig_scope_open, sclk, serial_data_line_in}),
		.pin_s(pin_s),
		.pin_prev(pin_p)
	);

	wire logic sclk_rise = pin_s[1] & ~pin_p[1];
	wire logic sclk_fall = ~pin_s[1] & pin_p[1];
	wire logic scope_open = pin_s[2];
	// A start condition is data falling while the clock stays low.
	wire logic ssc = ~pin_s[1] & ~pin_p[1] & pin_p[0] & ~pin_s[0];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	rfs_pkg::rfs_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [12:0] sh_ff, nxt_sh;
	logic [7:0] addr_ff, nxt_addr;
	logic [3:0] left_ff, nxt_left;
	logic shared_ff, nxt_shared;
	logic rd_ff, nxt_rd;
	logic sdo_ff, nxt_sdo;
	logic oe_ff, nxt_oe;
	rfs_pkg::rfs_wr_t wr_ff, nxt_wr;
	rfs_pkg::rfs_err_t err_ff, nxt_err;

	logic [6:0] mode_act_ff, nxt_mode_act;
	logic [6:0] mode_stg_ff, nxt_mode_stg;
	logic [1:0] pstate_ff, nxt_pstate;
	logic [2:0] mask_ff, nxt_mask;
	logic [6:0] status_ff, nxt_status;
	logic [3:0] group_ff, nxt_group;
	logic [3:0] unique_slave_address_ff, nxt_unique_slave_address;

	// ---------------------------------------------------------------
	// Map decoding
	// ---------------------------------------------------------------
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `RFS_ADR_MODE) ||
			((a >= `RFS_ADR_STATUS) && (a <= `RFS_ADR_PART_EXT));
	endfunction : addr_known

	// Read byte with its odd parity bit appended.
	function automatic logic [8:0] rd_frame(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`RFS_ADR_MODE: v = {1'b0, mode_act_ff};
			`RFS_ADR_STATUS: v = {1'b0, status_ff};
			`RFS_ADR_GROUP: v = {4'h0, group_ff};
			`RFS_ADR_PWR: v = {pstate_ff, mask_ff, 3'h0};
			`RFS_ADR_PART: v = PART_CODE;
			`RFS_ADR_MAKER_LO: v = MAKER_CODE[`RFS_MAKER_LO_FLD]; // RQ1
			`RFS_ADR_MAKER_HI: v = {2'h0, MAKER_CODE[`RFS_MAKER_TOP_FLD],
				unique_slave_address_ff}; // RQ1
			`RFS_ADR_PART_EXT: v = PART_CODE_EXT; // RQ10
			default: v = 8'h00;
		endcase
		rd_frame = {v, ~^v};
	endfunction : rd_frame

	// ---------------------------------------------------------------
	// Frame decoding
	// ---------------------------------------------------------------
	wire logic [12:0] frm = {sh_ff[11:0], pin_s[0]};
	wire logic [3:0] frm_sa = frm[`RFS_FRM_SA];
	wire logic [7:0] frm_cmd = frm[`RFS_FRM_CMD];
	wire logic [7:0] frm_data = frm[`RFS_FRM_DATA];
	wire logic par13_ok = ^frm;
	wire logic par9_ok = ^frm[8:0];
	wire logic for_unique_slave_address = frm_sa == unique_slave_address_ff; // RQ2
	wire logic for_shared = (frm_sa == `RFS_BCAST_ID) ||
		(frm_sa == group_ff);
	wire logic for_me = for_unique_slave_address | for_shared;
	wire logic op_r0w = frm_cmd[`RFS_CMD_R0W];
	wire logic op_rw = frm_cmd[`RFS_CMD_OP3] == `RFS_OP_RW;
	wire logic op_rr = frm_cmd[`RFS_CMD_OP3] == `RFS_OP_RR;
	wire logic op_ew = frm_cmd[`RFS_CMD_OP4] == `RFS_OP_EW;
	wire logic op_er = frm_cmd[`RFS_CMD_OP4] == `RFS_OP_ER;
	wire logic op_read = ~op_r0w & (op_rr | op_er);
	wire logic in_frame = |(state_ff & (rfs_pkg::st_addr |
		rfs_pkg::st_wdata | rfs_pkg::st_turn | rfs_pkg::st_rdata |
		rfs_pkg::st_rpark));
	wire logic [7:0] addr_inc = addr_ff + 8'h01;
	logic [8:0] next_byte;
	// A process wakes on the registers the function reads; an assign won't.
	always_comb next_byte = rd_frame(addr_inc);

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_addr = addr_ff;
		nxt_left = left_ff;
		nxt_shared = shared_ff;
		nxt_rd = rd_ff;
		nxt_sdo = sdo_ff;
		nxt_oe = oe_ff;
		nxt_wr = '0;
		nxt_err = '0;
		if (ssc) begin
			nxt_err.cmd_len = in_frame; // RQ4
			nxt_state = rfs_pkg::st_cmd;
			nxt_cnt = 4'h0;
			nxt_sdo = 1'b0;
			nxt_oe = 1'b0;
		end else begin
			unique case (state_ff)
				rfs_pkg::st_idle: begin
					nxt_oe = 1'b0;
				end
				rfs_pkg::st_cmd: begin
					if (sclk_fall) begin
						nxt_sh = frm;
						nxt_cnt = cnt_ff + 4'h1;
						if (cnt_ff == `RFS_CMD_LAST) begin
							nxt_cnt = 4'h0;
							nxt_state = rfs_pkg::st_idle;
							nxt_shared = ~for_unique_slave_address;
							nxt_addr = {3'h0, frm_cmd[`RFS_CMD_RADR]};
							nxt_left = 4'h0;
							nxt_rd = op_read;
							if (!par13_ok) begin
								nxt_err.cmd_par = for_me; // RQ4
							end else if (op_read && !for_unique_slave_address) begin
								nxt_err.shared_id_read_fault = for_shared; // RQ9
							end else if (for_me && op_r0w) begin
								nxt_wr.en = 1'b1;
								nxt_wr.shared = ~for_unique_slave_address;
								nxt_wr.addr = `RFS_ADR_MODE;
								nxt_wr.data = {1'b0, frm_cmd[`RFS_CMD_R0DATA]};
								nxt_state = rfs_pkg::st_wpark;
							end else if (for_me && op_rw) begin
								nxt_state = rfs_pkg::st_wdata;
							end else if (for_me && op_rr) begin
								nxt_state = rfs_pkg::st_turn;
							end else if (for_me && (op_ew || op_er)) begin
								nxt_left = frm_cmd[`RFS_CMD_BC];
								nxt_state = rfs_pkg::st_addr;
							end
						end
					end
				end
				rfs_pkg::st_addr: begin
					if (sclk_fall) begin
						nxt_sh = frm;
						nxt_cnt = cnt_ff + 4'h1;
						if (cnt_ff == `RFS_BYTE_LAST) begin
							nxt_cnt = 4'h0;
							nxt_addr = frm_data;
							if (!par9_ok) begin
								nxt_err.adr_par = 1'b1; // RQ5
								nxt_state = rfs_pkg::st_idle;
							end else if (rd_ff) begin
								nxt_state = rfs_pkg::st_turn;
							end else begin
								nxt_state = rfs_pkg::st_wdata;
							end
						end
					end
				end
				rfs_pkg::st_wdata: begin
					if (sclk_fall) begin
						nxt_sh = frm;
						nxt_cnt = cnt_ff + 4'h1;
						if (cnt_ff == `RFS_BYTE_LAST) begin
							nxt_cnt = 4'h0;
							nxt_wr.en = par9_ok;
							nxt_wr.shared = shared_ff;
							nxt_wr.addr = addr_ff;
							nxt_wr.data = frm_data;
							nxt_err.dat_par = ~par9_ok; // RQ6
							if (left_ff != 4'h0) begin
								nxt_left = left_ff - 4'h1;
								nxt_addr = addr_inc;
							end else begin
								nxt_state = rfs_pkg::st_wpark;
							end
						end
					end
				end
				rfs_pkg::st_wpark: begin
					if (sclk_fall) begin
						nxt_state = rfs_pkg::st_idle;
					end
				end
				rfs_pkg::st_turn: begin
					if (sclk_fall) begin
						nxt_sh = {4'h0, rd_frame(addr_ff)};
						nxt_cnt = 4'h0;
						nxt_err.rd_unused = ~addr_known(addr_ff); // RQ7
						nxt_state = rfs_pkg::st_rdata;
					end
				end
				rfs_pkg::st_rdata: begin
					if (sclk_rise) begin
						nxt_oe = 1'b1;
						if (cnt_ff != `RFS_BYTE_DONE) begin
							nxt_sdo = sh_ff[8];
							nxt_sh = {sh_ff[11:0], 1'b0};
							nxt_cnt = cnt_ff + 4'h1;
						end else if (left_ff != 4'h0) begin
							nxt_left = left_ff - 4'h1;
							nxt_addr = addr_inc;
							nxt_sdo = next_byte[8];
							nxt_sh = {4'h0, next_byte[7:0], 1'b0};
							nxt_cnt = 4'h1;
							nxt_err.rd_unused = ~addr_known(addr_inc); // RQ7
						end else begin
							nxt_sdo = 1'b0;
							nxt_state = rfs_pkg::st_rpark;
						end
					end
				end
				rfs_pkg::st_rpark: begin
					if (sclk_fall) begin
						nxt_oe = 1'b0;
						nxt_state = rfs_pkg::st_idle;
					end
				end
				default: begin
					nxt_oe = 1'b0;
					nxt_state = rfs_pkg::st_idle;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register file updates
	// ---------------------------------------------------------------
	// Group and broadcast writes reach only the trigger control register.
	wire logic wr_own = wr_ff.en & ~wr_ff.shared;
	wire logic sel_mode = wr_own & (wr_ff.addr == `RFS_ADR_MODE);
	wire logic sel_status = wr_own & (wr_ff.addr == `RFS_ADR_STATUS);
	wire logic sel_group = wr_own & (wr_ff.addr == `RFS_ADR_GROUP);
	wire logic sel_unique_slave_address = wr_own & (wr_ff.addr == `RFS_ADR_MAKER_HI);
	wire logic sel_pwr = wr_ff.en & (wr_ff.addr == `RFS_ADR_PWR);
	wire logic sw_reset = sel_status & wr_ff.data[`RFS_STAT_SWRST];
	wire logic wr_bad = wr_ff.en & ~addr_known(wr_ff.addr);
	wire logic [2:0] new_mask = wr_ff.data[`RFS_PWR_MASK_FLD];
	wire logic [2:0] fire = {3{sel_pwr}} &
		wr_ff.data[`RFS_PWR_TRIG_FLD] & ~new_mask;
	wire logic load_trig = scope_open ? fire[0] : |fire;
	wire logic direct = scope_open ? mask_ff[0] : &mask_ff;
	wire logic pstate_ok = wr_ff.data[`RFS_PWR_STATE_FLD] !=
		`RFS_PWR_RESERVED;

	always_comb begin
		nxt_status = status_ff;
		nxt_mode_act = mode_act_ff;
		nxt_mode_stg = mode_stg_ff;
		nxt_pstate = pstate_ff;
		nxt_mask = mask_ff;
		nxt_group = group_ff;
		nxt_unique_slave_address = unique_slave_address_ff;
		if (sel_status) begin
			nxt_status = wr_ff.data[6:0]; // RQ15
		end
		if (sel_group) begin
			nxt_group = wr_ff.data[`RFS_GROUP_FLD];
		end
		if (sel_unique_slave_address) begin
			nxt_unique_slave_address = wr_ff.data[`RFS_UNIQUE_SLAVE_ADDRESS_FLD]; // RQ2
		end
		if (sel_pwr) begin
			nxt_mask = new_mask; // RQ13
			if (pstate_ok) begin
				nxt_pstate = wr_ff.data[`RFS_PWR_STATE_FLD]; // RQ14
			end
		end
		if (load_trig) begin
			nxt_mode_act = mode_stg_ff; // RQ11 RQ12
		end
		if (sel_mode) begin
			nxt_mode_stg = wr_ff.data[`RFS_MODE_FLD];
			if (direct) begin
				nxt_mode_act = wr_ff.data[`RFS_MODE_FLD]; // RQ13
			end
		end
		if (sw_reset) begin
			nxt_status = `RFS_STATUS_RST; // RQ3
			nxt_mode_act = `RFS_MODE_RST; // RQ3
			nxt_mode_stg = `RFS_MODE_RST; // RQ3
		end
		// New events win over a clear in the same cycle.
		nxt_status = nxt_status | err_ff | {5'h00, wr_bad, 1'b0}; // RQ4 RQ8
	end

	// ---------------------------------------------------------------
	// Flip-flops
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= rfs_pkg::st_idle;
			cnt_ff <= 4'h0;
			sh_ff <= 13'h0000;
			addr_ff <= 8'h00;
			left_ff <= 4'h0;
			shared_ff <= 1'b0;
			rd_ff <= 1'b0;
			sdo_ff <= 1'b0;
			oe_ff <= 1'b0;
			wr_ff <= '0;
			err_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			addr_ff <= nxt_addr;
			left_ff <= nxt_left;
			shared_ff <= nxt_shared;
			rd_ff <= nxt_rd;
			sdo_ff <= nxt_sdo;
			oe_ff <= nxt_oe;
			wr_ff <= nxt_wr;
			err_ff <= nxt_err;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_ff <= `RFS_STATUS_RST;
			mode_act_ff <= `RFS_MODE_RST;
			mode_stg_ff <= `RFS_MODE_RST;
			pstate_ff <= `RFS_PSTATE_RST;
			mask_ff <= `RFS_MASK_RST;
			group_ff <= `RFS_GROUP_RST;
			unique_slave_address_ff <= `RFS_UNIQUE_SLAVE_ADDRESS_RST;
		end else begin
			status_ff <= nxt_status;
			mode_act_ff <= nxt_mode_act;
			mode_stg_ff <= nxt_mode_stg;
			pstate_ff <= nxt_pstate;
			mask_ff <= nxt_mask;
			group_ff <= nxt_group;
			unique_slave_address_ff <= nxt_unique_slave_address;
		end
	end

	assign serial_data_line_out = sdo_ff;
	assign serial_data_line_oe = oe_ff;
	assign mode_ctrl = mode_act_ff;
	assign power_state = pstate_ff;

endmodule : rfs_slave_regs

`default_nettype wire

// [dv/rfs_slave_regs_monitor.sv]
// Pin-level checks on the serial slave register bank.
// Assumes a bind onto rfs_slave_regs, with clk far faster than sclk.
`default_nettype none

module rfs_slave_regs_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Link and strap
	input wire logic sclk,
	input wire logic serial_data_line_in,
	input wire logic serial_data_line_out,
	input wire logic serial_data_line_oe,
	input wire logic trig_scope_open,
	// Switch control
	input wire logic [6:0] mode_ctrl,
	input wire logic [1:0] power_state
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sclk_ff;
	logic [5:0] still_ff;
	logic [5:0] nxt_still;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Counts cycles since sclk last moved, saturating.
	assign nxt_still = (sclk != sclk_ff) ? 6'h00 :
		(still_ff == 6'h3F) ? still_ff : still_ff + 6'h01;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_ff <= 1'b0;
			still_ff <= 6'h00;
		end else begin
			sclk_ff <= sclk;
			still_ff <= nxt_still;
		end
	end

	chk_reset_values: assert property (
		$rose(resetn) |-> !serial_data_line_oe && mode_ctrl == 7'h00
		&& power_state == 2'h0)
		else $error("outputs not at reset values");
	chk_pstate_legal: assert property (
		power_state != 2'h3)
		else $error("reserved power state shown");
	chk_pstate_timing: assert property (
		$changed(power_state) |-> !sclk)
		else $error("power state moved inside a bit");
	chk_mode_timing: assert property (
		$changed(mode_ctrl) |-> !sclk && !serial_data_line_oe)
		else $error("mode moved outside a write end");
	chk_oe_rise: assert property (
		$rose(serial_data_line_oe) |-> sclk ##1 serial_data_line_oe[*8])
		else $error("read drive not held");
	chk_out_stable: assert property (
		serial_data_line_oe && $changed(serial_data_line_out) |-> sclk)
		else $error("read bit changed while sclk low");
	chk_park_release: assert property (
		$fell(serial_data_line_oe) |-> !sclk && !$past(serial_data_line_out))
		else $error("slave park bit wrong");
	chk_oe_framed: assert property (
		still_ff > 6'h18 |-> !serial_data_line_oe)
		else $error("slave drives an idle link");
endmodule : rfs_slave_regs_monitor

`default_nettype wire

// [dv/rfs_master_model.sv]
// Bus master model: frames on sclk and the data wire, clock still idle.
// Assumes the bench resolves the wire with a pull-down.
`default_nettype none

module rfs_master_model (
	// Clock reference
	input wire logic clk,
	// Link pins
	output logic sclk,
	output logic m_dat,
	output logic m_oe,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'b0;
		m_dat = 1'b0;
		m_oe = 1'b0;
	end

	// Data moves just after the rise and holds past the fall.
	task automatic bit_tx(input logic b);
		sclk = 1'b1;
		#10;
		m_oe = 1'b1;
		m_dat = b;
		#70;
		sclk = 1'b0;
		#80;
	endtask : bit_tx

	// Start condition, address, command and odd parity.
	task automatic cmd(input logic [3:0] sa, input logic [7:0] c,
		input logic bad);
		logic [11:0] w;
		w = {sa, c};
		@(negedge clk);
		m_oe = 1'b1;
		m_dat = 1'b1;
		#80;
		m_dat = 1'b0;
		#80;
		for (int i = 11; i >= 0; i--) bit_tx(w[i]);
		bit_tx(~^w ^ bad);
	endtask : cmd

	task automatic dat(input logic [7:0] d, input logic bad);
		for (int i = 7; i >= 0; i--) bit_tx(d[i]);
		bit_tx(~^d ^ bad);
	endtask : dat

	task automatic park();
		bit_tx(1'b0);
		m_oe = 1'b0;
	endtask : park

	// Nine bits in, then the slave's own park bit.
	task automatic rd(output logic [8:0] v);
		for (int i = 9; i >= 0; i--) begin
			sclk = 1'b1;
			#70;
			if (i > 0) v[i - 1] = line;
			#10;
			sclk = 1'b0;
			#80;
		end
	endtask : rd
endmodule : rfs_master_model

`default_nettype wire

// [dv/test_rfs_slave_regs.sv]
// Self-checking bench for the serial slave register bank.
// Assumes the monitor and master model are compiled first.
`default_nettype none

module test_rfs_slave_regs;
	timeunit 1ns;
	timeprecision 100ps;
	// Identity codes; the values are arbitrary.
	localparam logic [9:0] MAKER = 10'h1C6;
	localparam logic [7:0] PART = 8'h4D;
	localparam logic [7:0] PEXT = 8'h61;
	localparam logic [3:0] U = 4'hB;
	logic clk, resetn, sclk, m_dat, m_oe, line, serial_data_line_out, serial_data_line_oe;
	logic trig_open;
	logic [6:0] mode_ctrl, m1, m2, m3;
	logic [1:0] power_state;
	logic [7:0] d, a;
	logic [8:0] v;
	logic [3:0] nu, g;
	logic [7:0] ta [8];
	logic [7:0] te [8];
	int bad_count, comparisons;

	assign line = serial_data_line_oe ? serial_data_line_out : (m_oe ? m_dat : 1'b0);

	rfs_slave_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART),
		.PART_CODE_EXT(PEXT)) uut (.clk(clk), .resetn(resetn),
		.sclk(sclk), .serial_data_line_in(line), .serial_data_line_out(serial_data_line_out),
		.serial_data_line_oe(serial_data_line_oe), .trig_scope_open(trig_open),
		.mode_ctrl(mode_ctrl), .power_state(power_state));
	rfs_master_model mdl (.clk(clk), .sclk(sclk), .m_dat(m_dat),
		.m_oe(m_oe), .line(line));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h not %h", $time, got, exp);
		end
	endtask : check

	// Power state left after writing code over prev; code 3 is ignored.
	function automatic logic [7:0] pstate_exp(input logic [1:0] prev,
		input logic [1:0] code);
		pstate_exp = {6'h00, (code == 2'h3) ? prev : code};
	endfunction : pstate_exp

	// Register write; e flags a bad command or data parity.
	task automatic wr(input logic [3:0] sa, input logic [7:0] ad,
		input logic [7:0] dv, input logic [1:0] e);
		mdl.cmd(sa, {3'h2, ad[4:0]}, e[1]);
		mdl.dat(dv, e[0]);
		mdl.park();
		#200;
	endtask : wr

	// Addresses above 0x1F need the extended read.
	task automatic rd(input logic [3:0] sa, input logic [7:0] ad,
		output logic [7:0] dv);
		logic [8:0] r;
		if (ad > 8'h1F) begin
			mdl.cmd(sa, 8'h20, 1'b0);
			mdl.dat(ad, 1'b0);
		end else begin
			mdl.cmd(sa, {3'h3, ad[4:0]}, 1'b0);
		end
		mdl.park();
		mdl.rd(r);
		dv = r[8:1];
		check({7'h00, r[0]}, {7'h00, ~^r[8:1]});
		#200;
	endtask : rd

	task automatic stat(input logic [7:0] exp);
		rd(U, 8'h1A, d);
		check(d, exp);
	endtask : stat

	task automatic complete_run();
		$display("mismatches %0d of %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#400000;
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		resetn = 1'b0;
		trig_open = 1'b1;
		void'($urandom(97804));
		ta = '{8'h00, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
		te = '{8'h00, 8'h00, 8'h00, 8'h00, PART, MAKER[7:0],
			{2'h0, MAKER[9:8], U}, PEXT};
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			rd(U, ta[i], d);
			check(d, te[i]);
		end
		nu = 4'($urandom_range(1, 10));
		wr(U, 8'h1E, 8'($urandom), 2'h0);
		wr(U, 8'h1D, 8'($urandom), 2'h0);
		wr(U, 8'h1F, {4'($urandom), nu}, 2'h0);
		for (int i = 4; i < 7; i++) begin
			rd(nu, ta[i], d);
			check(d, (i == 6) ? {te[i][7:4], nu} : te[i]);
		end
		wr(nu, 8'h1F, {4'h0, U}, 2'h0);
		stat(8'h00);
		repeat (3) begin
			a = 8'($urandom_range(1, 25));
			rd(U, a, d);
			check(d, 8'h00);
			stat(8'h04);
			wr(U, a, 8'($urandom), 2'h0);
			stat(8'h06);
			wr(U, 8'h1A, 8'h00, 2'h0);
			stat(8'h00);
		end
		wr(U, 8'h1B, 8'h05, 2'h2);
		stat(8'h40);
		wr(U, 8'h1B, 8'h05, 2'h1);
		stat(8'h48);
		mdl.cmd(U, 8'h5B, 1'b0);
		repeat (4) mdl.bit_tx(1'b1);
		stat(8'h68);
		mdl.cmd(U, 8'h00, 1'b0);
		mdl.dat(8'h1B, 1'b1);
		mdl.dat(8'h09, 1'b0);
		mdl.park();
		#200;
		stat(8'h78);
		rd(U, 8'h1B, d);
		check(d, 8'h00);
		wr(U, 8'h1A, 8'h00, 2'h0);
		g = 4'($urandom_range(1, 10));
		wr(U, 8'h1B, {4'($urandom), ~g}, 2'h0);
		// Extended write of two bytes: group address, then trigger control.
		mdl.cmd(U, 8'h01, 1'b0);
		mdl.dat(8'h1B, 1'b0);
		mdl.dat({4'($urandom), g}, 1'b0);
		mdl.dat(8'h00, 1'b0);
		mdl.park();
		#200;
		for (int i = 0; i < 2; i++) begin
			mdl.cmd(i ? g : 4'h0, 8'h7A, 1'b0);
			mdl.park();
			mdl.rd(v);
			check(v[8:1], 8'h00);
			stat(8'h01);
		end
		for (int i = 0; i < 4; i++) begin
			wr(U, 8'h1C, {2'(i), 6'h00}, 2'h0);
			check({6'h00, power_state}, pstate_exp(2'h2, 2'(i)));
		end
		wr(g, 8'h1C, 8'h40, 2'h0);
		check({6'h00, power_state}, 8'h01);
		m1 = 7'($urandom_range(1, 127));
		m2 = 7'($urandom_range(1, 127));
		m3 = 7'($urandom_range(1, 127));
		wr(U, 8'h00, {1'b0, m1}, 2'h0);
		check({1'b0, mode_ctrl}, 8'h00);
		wr(U, 8'h1C, 8'h06, 2'h0);
		check({1'b0, mode_ctrl}, 8'h00);
		wr(U, 8'h1C, 8'h01, 2'h0);
		check({1'b0, mode_ctrl}, {1'b0, m1});
		wr(U, 8'h1C, 8'h08, 2'h0);
		mdl.cmd(U, {1'b1, m2}, 1'b0);
		mdl.park();
		#200;
		check({1'b0, mode_ctrl}, {1'b0, m2});
		@(negedge clk) trig_open = 1'b0;
		wr(U, 8'h00, {1'b0, m3}, 2'h0);
		check({1'b0, mode_ctrl}, {1'b0, m2});
		wr(U, 8'h1C, 8'h0C, 2'h0);
		check({1'b0, mode_ctrl}, {1'b0, m3});
		wr(U, 8'h1C, 8'h38, 2'h0);
		wr(U, 8'h00, {1'b0, m1}, 2'h0);
		check({1'b0, mode_ctrl}, {1'b0, m1});
		wr(U, 8'h1A, 8'h80, 2'h0);
		check({1'b0, mode_ctrl}, 8'h00);
		rd(U, 8'h1C, d);
		check(d, 8'h38);
		rd(U, 8'h1B, d);
		check(d, {4'h0, g});
		stat(8'h00);
		complete_run();
	end
endmodule : test_rfs_slave_regs

bind rfs_slave_regs rfs_slave_regs_monitor mon (.clk(clk),
	.resetn(resetn), .sclk(sclk), .serial_data_line_in(serial_data_line_in),
	.serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
	.trig_scope_open(trig_scope_open), .mode_ctrl(mode_ctrl),
	.power_state(power_state));

`default_nettype wire
